/* pkg/flow_ctrl_defines.vh */
`ifndef FLOW_CTRL_DEFINES_VH
`define FLOW_CTRL_DEFINES_VH
`define ADR_BANK_SEL 8'h00
`define ADR_SCRATCH 8'h04
`define ADR_DIV_LOW 8'h08
`define ADR_DIV_HIGH 8'h0C
`define ADR_TX_SPACE 8'h10
`define ADR_RX_FILL 8'h14
`define ADR_IEN 8'h18
`define ADR_FIFO_CTL 8'h1C
`define ADR_MODEM_CTL 8'h20
`define ADR_INT_STAT 8'h24
`define ADR_EFC 8'h28
`define ADR_RES1 8'h2C
`define ADR_RES2 8'h30
`define ADR_PAU1 8'h34
`define ADR_PAU2 8'h38
`define ADR_RX_TRIG 8'h3C
`define ADR_FLOW_HI 8'h40
`define ADR_FLOW_LO 8'h44
`define BANK_GEN 2'b00
`define BANK_FIRST 2'b01
`define BANK_SECOND 2'b10
`define EFC_AUTO_CTS 7
`define EFC_AUTO_RTS 6
`define EFC_SPECIAL 5
`define EFC_ENH 4
`define ISR_SPECIAL 4
`define ISR_RX_TRIG 2
`define MCR_RTS 1
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define RST_BYTE 8'h00
`define RST_FLOW_HI 8'h60
`define RST_FLOW_LO 8'h20
`define RST_RX_TRIG 8'h40
`endif

/* src/uart_enhanced_feature_flow_ctrl.v */
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "flow_ctrl_defines.vh"
module uart_enhanced_feature_flow_ctrl (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // FIFO levels and modem status from the core
   input wire [7:0] tx_space_in,
   input wire [7:0] rx_fill_in,
   input wire [7:0] modem_status_in,
   // Modem pins
   input wire cts_pin,
   output reg rts_pin_r,
   // Transmitter
   input wire tx_busy,
   output reg tx_enable_r,
   output reg tx_flow_valid_r,
   output reg [7:0] tx_flow_char_r,
   input wire tx_flow_ready,
   // Receiver
   input wire rx_valid,
   input wire [7:0] rx_char,
   output reg rx_store_valid_r,
   output reg [7:0] rx_store_char_r,
   // Configuration and status out
   output reg [15:0] baud_divisor_r,
   output reg [7:0] int_status_r
);

   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_SEND1 = 3'b010;
   localparam [2:0] ST_SEND2 = 3'b100;

   reg [1:0] bank_r;
   reg lvl_en_r;
   reg [7:0] scratch_r;
   reg [7:0] ien_r;
   reg [7:0] fifo_ctl_r;
   reg [7:0] modem_ctl_r;
   reg [7:0] efc_r;
   reg [7:0] res1_r;
   reg [7:0] res2_r;
   reg [7:0] pau1_r;
   reg [7:0] pau2_r;
   reg [7:0] rx_trig_r;
   reg [7:0] flow_hi_r;
   reg [7:0] flow_lo_r;
   reg [7:0] awaddr_r;
   reg aw_have_r;
   reg [7:0] wdata_r;
   reg w_have_r;
   reg special_r;
   reg auto_rts_r;
   reg paused_r;
   reg [7:0] prev_char_r;
   reg prev_valid_r;
   reg rx_off_r;
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg send_off_r;

   wire wr_go;
   wire rd_go;
   wire enh;
   wire [1:0] tx_mode;
   wire [1:0] rx_mode;
   wire hit_on;
   wire hit_off;
   wire is_flow;
   wire special_hit;
   wire rd_special;
   wire need_off;
   wire need_on;

   ////////////////////////////////////////////////////////////////////////
   // Register decode
   function reg_ok;
      input [7:0] adr;
      input [1:0] bank;
      input lvl;
      input wr;
      begin
         case (adr)
            `ADR_BANK_SEL: reg_ok = 1'b1;
            `ADR_SCRATCH, `ADR_DIV_LOW, `ADR_DIV_HIGH, `ADR_IEN,
            `ADR_FIFO_CTL, `ADR_MODEM_CTL: reg_ok = (bank == `BANK_GEN);
            `ADR_INT_STAT: reg_ok = (bank == `BANK_GEN) && !wr;
            `ADR_TX_SPACE, `ADR_RX_FILL:
               reg_ok = !wr && lvl && (bank == `BANK_GEN);
            `ADR_EFC, `ADR_RES1, `ADR_RES2, `ADR_PAU1, `ADR_PAU2:
               reg_ok = (bank == `BANK_FIRST);
            `ADR_RX_TRIG, `ADR_FLOW_HI, `ADR_FLOW_LO:
               reg_ok = (bank == `BANK_SECOND);
            default: reg_ok = 1'b0;
         endcase
      end
   endfunction

   // Gate enhanced bits of a byte with the enhanced-function enable
   function [7:0] enh_merge;
      input [7:0] old;
      input [7:0] nw;
      input [7:0] mask;
      input en;
      begin
         enh_merge = en ? nw : ((old & mask) | (nw & ~mask));
      end
   endfunction

   assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
   assign rd_go = s_axi_arvalid && s_axi_arready;
   assign enh = efc_r[`EFC_ENH];
   assign tx_mode = efc_r[3:2];
   assign rx_mode = efc_r[1:0];
   assign rd_special = rd_go && (s_axi_araddr == `ADR_INT_STAT) &&
      reg_ok(s_axi_araddr, bank_r, lvl_en_r, 1'b0);

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channel
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         awaddr_r <= `RST_BYTE;
         wdata_r <= `RST_BYTE;
      end else begin
         s_axi_awready <= !aw_have_r && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= !w_have_r && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            s_axi_awready <= 1'b0;
            awaddr_r <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            s_axi_wready <= 1'b0;
            wdata_r <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
         end
         if (wr_go) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= reg_ok(awaddr_r, bank_r, lvl_en_r, 1'b1) ?
               `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register storage
   always @(posedge aclk) begin
      if (!aresetn) begin
         bank_r <= `BANK_GEN;
         lvl_en_r <= 1'b0;
         scratch_r <= `RST_BYTE;
         baud_divisor_r <= 16'h0000;
         ien_r <= `RST_BYTE;
         fifo_ctl_r <= `RST_BYTE;
         modem_ctl_r <= `RST_BYTE;
         efc_r <= `RST_BYTE;
         res1_r <= `RST_BYTE;
         res2_r <= `RST_BYTE;
         pau1_r <= `RST_BYTE;
         pau2_r <= `RST_BYTE;
         rx_trig_r <= `RST_RX_TRIG;
         flow_hi_r <= `RST_FLOW_HI;
         flow_lo_r <= `RST_FLOW_LO;
      end else if (wr_go && w_have_r &&
                   reg_ok(awaddr_r, bank_r, lvl_en_r, 1'b1)) begin
         case (awaddr_r)
            `ADR_BANK_SEL: begin
               bank_r <= wdata_r[2:1];
               lvl_en_r <= wdata_r[0];
            end
            `ADR_SCRATCH: scratch_r <= wdata_r;
            `ADR_DIV_LOW: baud_divisor_r[7:0] <= wdata_r;
            `ADR_DIV_HIGH: baud_divisor_r[15:8] <= wdata_r;
            `ADR_IEN: ien_r <= enh_merge(ien_r, wdata_r, 8'hF0, enh);
            `ADR_FIFO_CTL:
               fifo_ctl_r <= enh_merge(fifo_ctl_r, wdata_r, 8'h30, enh);
            `ADR_MODEM_CTL:
               modem_ctl_r <= enh_merge(modem_ctl_r, wdata_r, 8'hE0, enh);
            `ADR_EFC: efc_r <= wdata_r;
            `ADR_RES1: res1_r <= wdata_r;
            `ADR_RES2: res2_r <= wdata_r;
            `ADR_PAU1: pau1_r <= wdata_r;
            `ADR_PAU2: pau2_r <= wdata_r;
            `ADR_RX_TRIG: rx_trig_r <= wdata_r;
            `ADR_FLOW_HI: flow_hi_r <= wdata_r;
            `ADR_FLOW_LO: flow_lo_r <= wdata_r;
            default: bank_r <= bank_r;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channel
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (rd_go) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
            if (reg_ok(s_axi_araddr, bank_r, lvl_en_r, 1'b0)) begin
               s_axi_rresp <= `RESP_OKAY;
               case ({s_axi_araddr[7:2], 2'b00})
                  `ADR_BANK_SEL: s_axi_rdata[7:0] <= modem_status_in;
                  `ADR_SCRATCH: s_axi_rdata[7:0] <= scratch_r;
                  `ADR_DIV_LOW: s_axi_rdata[7:0] <= baud_divisor_r[7:0];
                  `ADR_DIV_HIGH: s_axi_rdata[7:0] <= baud_divisor_r[15:8];
                  `ADR_TX_SPACE: s_axi_rdata[7:0] <= tx_space_in;
                  `ADR_RX_FILL: s_axi_rdata[7:0] <= rx_fill_in;
                  `ADR_IEN: s_axi_rdata[7:0] <= ien_r;
                  `ADR_FIFO_CTL: s_axi_rdata[7:0] <= fifo_ctl_r;
                  `ADR_MODEM_CTL: s_axi_rdata[7:0] <= modem_ctl_r;
                  `ADR_INT_STAT: s_axi_rdata[7:0] <= int_status_r;
                  `ADR_EFC: s_axi_rdata[7:0] <= efc_r;
                  `ADR_RES1: s_axi_rdata[7:0] <= res1_r;
                  `ADR_RES2: s_axi_rdata[7:0] <= res2_r;
                  `ADR_PAU1: s_axi_rdata[7:0] <= pau1_r;
                  `ADR_PAU2: s_axi_rdata[7:0] <= pau2_r;
                  `ADR_RX_TRIG: s_axi_rdata[7:0] <= rx_trig_r;
                  `ADR_FLOW_HI: s_axi_rdata[7:0] <= flow_hi_r;
                  `ADR_FLOW_LO: s_axi_rdata[7:0] <= flow_lo_r;
                  default: s_axi_rdata <= 32'h0000_0000;
               endcase
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive character compare
   // Single mode 10 first pair, 01 second; 11 either pair unless the
   // transmit side also runs both pairs, then two-character sequences.
   wire seq_mode = (rx_mode == 2'b11) && (tx_mode == 2'b11);
   wire m_on1 = (rx_char == res1_r);
   wire m_on2 = (rx_char == res2_r);
   wire m_off1 = (rx_char == pau1_r);
   wire m_off2 = (rx_char == pau2_r);
   assign hit_on = seq_mode ?
      (prev_valid_r && prev_char_r == res1_r && m_on2) :
      ((rx_mode[1] && m_on1) || (rx_mode[0] && m_on2));
   assign hit_off = seq_mode ?
      (prev_valid_r && prev_char_r == pau1_r && m_off2) :
      ((rx_mode[1] && m_off1) || (rx_mode[0] && m_off2));
   assign is_flow = !seq_mode && (hit_on || hit_off);
   assign special_hit = efc_r[`EFC_SPECIAL] && m_off2;

   always @(posedge aclk) begin
      if (!aresetn) begin
         paused_r <= 1'b0;
         prev_char_r <= `RST_BYTE;
         prev_valid_r <= 1'b0;
         rx_store_valid_r <= 1'b0;
         rx_store_char_r <= `RST_BYTE;
         special_r <= 1'b0;
      end else begin
         rx_store_valid_r <= 1'b0;
         if (rx_valid) begin
            prev_char_r <= rx_char;
            prev_valid_r <= 1'b1;
            rx_store_char_r <= rx_char;
            rx_store_valid_r <= special_hit || !is_flow;
            if (hit_off)
               paused_r <= 1'b1;
            else if (hit_on)
               paused_r <= 1'b0;
         end
         if (rx_mode == 2'b00)
            paused_r <= 1'b0;
         // Set wins over the clear-on-read
         if (rx_valid && special_hit)
            special_r <= 1'b1;
         else if (rd_special)
            special_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Hardware flow control
   always @(posedge aclk) begin
      if (!aresetn) begin
         auto_rts_r <= 1'b0;
         rts_pin_r <= 1'b1;
         tx_enable_r <= 1'b1;
         int_status_r <= `RST_BYTE;
      end else begin
         if (rx_fill_in >= flow_hi_r)
            auto_rts_r <= 1'b1;
         else if (rx_fill_in < flow_lo_r)
            auto_rts_r <= 1'b0;
         if (efc_r[`EFC_AUTO_RTS])
            rts_pin_r <= auto_rts_r;
         else
            rts_pin_r <= !modem_ctl_r[`MCR_RTS];
         if (!tx_busy)
            tx_enable_r <= !(efc_r[`EFC_AUTO_CTS] && cts_pin) &&
               !paused_r;
         int_status_r <= `RST_BYTE;
         int_status_r[`ISR_SPECIAL] <= special_r;
         int_status_r[`ISR_RX_TRIG] <= efc_r[`EFC_AUTO_RTS] &&
            (rx_fill_in >= rx_trig_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmit flow characters
   assign need_off = (tx_mode != 2'b00) && !rx_off_r &&
      (rx_fill_in >= flow_hi_r);
   assign need_on = (tx_mode != 2'b00) && rx_off_r &&
      (rx_fill_in < flow_lo_r);

   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:
            if (need_off || need_on)
               state_nxt = ST_SEND1;
         ST_SEND1:
            if (tx_flow_valid_r && tx_flow_ready)
               state_nxt = (tx_mode == 2'b11) ? ST_SEND2 : ST_IDLE;
         ST_SEND2:
            if (tx_flow_valid_r && tx_flow_ready)
               state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= ST_IDLE;
         rx_off_r <= 1'b0;
         send_off_r <= 1'b0;
         tx_flow_valid_r <= 1'b0;
         tx_flow_char_r <= `RST_BYTE;
      end else begin
         state_r <= state_nxt;
         if (tx_mode == 2'b00)
            rx_off_r <= 1'b0;
         case (state_r)
            ST_IDLE:
               if (need_off || need_on) begin
                  send_off_r <= need_off;
                  rx_off_r <= need_off;
                  tx_flow_valid_r <= 1'b1;
                  // Mode 01 sends the second pair, else the first
                  if (tx_mode == 2'b01)
                     tx_flow_char_r <= need_off ? pau2_r : res2_r;
                  else
                     tx_flow_char_r <= need_off ? pau1_r : res1_r;
               end
            ST_SEND1:
               if (tx_flow_ready) begin
                  tx_flow_valid_r <= (tx_mode == 2'b11);
                  tx_flow_char_r <= send_off_r ? pau2_r : res2_r;
               end
            ST_SEND2:
               if (tx_flow_ready)
                  tx_flow_valid_r <= 1'b0;
            default: tx_flow_valid_r <= 1'b0;
         endcase
      end
   end

endmodule // uart_enhanced_feature_flow_ctrl

/* tb/flow_ctrl_properties.sv */
`timescale 1ns/1ps
`include "flow_ctrl_defines.vh"
module flow_ctrl_properties (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Bus answers
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   // Line side, status and baud divisor
   input wire tx_busy,
   input wire tx_enable_r,
   input wire tx_flow_valid_r,
   input wire [7:0] tx_flow_char_r,
   input wire tx_flow_ready,
   input wire rx_valid,
   input wire [7:0] rx_char,
   input wire rx_store_valid_r,
   input wire [7:0] rx_store_char_r,
   input wire rts_pin_r,
   input wire [7:0] int_status_r,
   input wire [15:0] baud_divisor_r
);
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
////////////////////////////////////////////////////////////////////////////
property p_b_hold;
   s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
endproperty
a_b_hold: assert property (p_b_hold) else $error("write answer lost");
property p_r_hold;
   s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
endproperty
a_r_hold: assert property (p_r_hold) else $error("read answer lost");
property p_byte;
   s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000;
endproperty
a_byte: assert property (p_byte) else $error("read upper bits set");
property p_slverr;
   s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == 0;
endproperty
a_slverr: assert property (p_slverr) else $error("refused read data");
property p_store;
   rx_store_valid_r |-> $past(rx_valid) && rx_store_char_r == $past(rx_char);
endproperty
a_store: assert property (p_store) else $error("stored char wrong");
property p_boundary;
   $changed(tx_enable_r) |-> !$past(tx_busy);
endproperty
a_boundary: assert property (p_boundary) else $error("mid-char halt");
property p_flow_hold;
   tx_flow_valid_r && !tx_flow_ready |=>
      tx_flow_valid_r && $stable(tx_flow_char_r);
endproperty
a_flow_hold: assert property (p_flow_hold) else $error("flow char lost");
property p_special;
   $rose(int_status_r[`ISR_SPECIAL]) |->
      $past(rx_store_valid_r) || $past(rx_store_valid_r, 2);
endproperty
a_special: assert property (p_special) else $error("status w/o char");
property p_rst;
   $past(!aresetn) |-> rts_pin_r && tx_enable_r && int_status_r == 8'h00 &&
      baud_divisor_r == 16'h0000;
endproperty
a_rst: assert property (p_rst) else $error("reset state wrong");
c_store: cover property (rx_store_valid_r);
c_flow: cover property (tx_flow_valid_r && tx_flow_ready);
c_halt: cover property ($fell(tx_enable_r));
endmodule // flow_ctrl_properties
bind uart_enhanced_feature_flow_ctrl flow_ctrl_properties u_props (
   .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .tx_busy(tx_busy),
   .tx_enable_r(tx_enable_r), .tx_flow_valid_r(tx_flow_valid_r),
   .tx_flow_char_r(tx_flow_char_r), .tx_flow_ready(tx_flow_ready),
   .rx_valid(rx_valid), .rx_char(rx_char),
   .rx_store_valid_r(rx_store_valid_r), .rx_store_char_r(rx_store_char_r),
   .rts_pin_r(rts_pin_r), .int_status_r(int_status_r),
   .baud_divisor_r(baud_divisor_r));

/* tb/peer_link.sv */
`timescale 1ns/1ps
module peer_link (
   // Clock
   input wire aclk,
   // Flow characters out of the block
   input wire tx_flow_valid,
   input wire [7:0] tx_flow_char,
   output logic tx_flow_ready,
   // Received characters into the block
   output logic rx_valid,
   output logic [7:0] rx_char
);
int stall = 0;
int cnt = 0;
logic [7:0] got [$];
initial begin
   tx_flow_ready = 1'b0;
   rx_valid = 1'b0;
   rx_char = 8'h00;
end
// Slow acceptance of flow characters, counted in stall cycles
always @(posedge aclk) begin
   tx_flow_ready <= 1'b0;
   if (tx_flow_valid && tx_flow_ready) begin
      got.push_back(tx_flow_char);
      cnt = 0;
   end else if (tx_flow_valid) begin
      if (cnt >= stall) tx_flow_ready <= 1'b1;
      else cnt++;
   end
end
// Line shows the inverse once the character is gone
task send(input logic [7:0] c);
   @(posedge aclk);
   rx_valid <= 1'b1;
   rx_char <= c;
   @(posedge aclk);
   rx_valid <= 1'b0;
   rx_char <= ~c;
   repeat (3) @(posedge aclk);
endtask
endmodule // peer_link

/* tb/test_uart_enhanced_feature_flow_ctrl.sv */
`timescale 1ns/1ps
`include "flow_ctrl_defines.vh"
module test_uart_enhanced_feature_flow_ctrl;
logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, cts, busy;
logic [7:0] awaddr, araddr, space, fill, mstat, last_st;
logic [31:0] wdata, v;
wire awready, wready, bvalid, arready, rvalid, rts, ten, fv, fr, rv, sv;
wire [1:0] bresp, rresp;
wire [31:0] rdata;
wire [7:0] fc, rc, sc, interrupt_status;
wire [15:0] div;
int mismatches = 0, total_checks = 0, stores = 0, n0, k;
// Rows: bank select, address, write, expected read, response
logic [33:0] rows [0:10] = '{{8'h00, 8'h04, 8'h5a, 8'h5a, 2'b00},
   {8'h00, 8'h08, 8'h34, 8'h34, 2'b00}, {8'h00, 8'h0c, 8'h12, 8'h12, 2'b00},
   {8'h02, 8'h04, 8'h77, 8'h00, 2'b10}, {8'h02, 8'h34, 8'h13, 8'h13, 2'b00},
   {8'h02, 8'h38, 8'h93, 8'h93, 2'b00}, {8'h02, 8'h2c, 8'h11, 8'h11, 2'b00},
   {8'h02, 8'h30, 8'h91, 8'h91, 2'b00}, {8'h04, 8'h40, 8'h05, 8'h05, 2'b00},
   {8'h04, 8'h44, 8'h02, 8'h02, 2'b00}, {8'h06, 8'h04, 8'h66, 8'h00, 2'b10}};
logic [23:0] sw [0:2] = '{24'h02_1311, 24'h01_9391, 24'h0b_9311};
logic [39:0] tw [0:2] = '{40'h08_1311_0000, 40'h04_9391_0000,
   40'h0c_1393_1191};
uart_enhanced_feature_flow_ctrl uut (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
   .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
   .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
   .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
   .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
   .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_space_in(space),
   .rx_fill_in(fill), .modem_status_in(mstat), .cts_pin(cts),
   .rts_pin_r(rts), .tx_busy(busy), .tx_enable_r(ten),
   .tx_flow_valid_r(fv), .tx_flow_char_r(fc), .tx_flow_ready(fr),
   .rx_valid(rv), .rx_char(rc), .rx_store_valid_r(sv),
   .rx_store_char_r(sc), .baud_divisor_r(div), .int_status_r(interrupt_status));
peer_link peer (.aclk(aclk), .tx_flow_valid(fv), .tx_flow_char(fc),
   .tx_flow_ready(fr), .rx_valid(rv), .rx_char(rc));
initial begin
   aclk = 1'b0;
   forever #2 aclk = ~aclk;
end
always @(posedge aclk) if (sv === 1'b1) begin
   stores <= stores + 1;
   last_st <= sc;
end
////////////////////////////////////////////////////////////////////////////
task complete_run;
   $display("checks %0d mismatches %0d", total_checks, mismatches);
   if (mismatches == 0 && total_checks > 0) $display("Finished cleanly");
   else $display("Finished with errors");
   $finish;
endtask
task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
   total_checks++;
   if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
   end
endtask
task to(input int n);
   if (n >= 99) begin
      mismatches++;
      complete_run;
   end
endtask
task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
   int n;
   bit ta, td;
   @(posedge aclk);
   awaddr <= a;
   wdata <= {24'h00_0000, d};
   awvalid <= 1'b1;
   wvalid <= 1'b1;
   bready <= 1'b1;
   n = 0;
   ta = 0;
   td = 0;
   while (!(ta && td) && n < 99) begin
      @(posedge aclk);
      n++;
      if (awready && !ta) begin ta = 1; awvalid <= 1'b0; end
      if (wready && !td) begin td = 1; wvalid <= 1'b0; end
   end
   while (bvalid !== 1'b1 && n < 99) begin @(posedge aclk); n++; end
   to(n);
   bready <= 1'b0;
   chk("bresp", bresp, er);
endtask
task rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
   int n;
   @(posedge aclk);
   araddr <= a;
   arvalid <= 1'b1;
   rready <= 1'b1;
   n = 0;
   do begin @(posedge aclk); n++; end while (arready !== 1'b1 && n < 99);
   arvalid <= 1'b0;
   while (rvalid !== 1'b1 && n < 99) begin @(posedge aclk); n++; end
   to(n);
   rready <= 1'b0;
   chk("rdata", rdata, {24'h00_0000, e});
   chk("rresp", rresp, er);
endtask
task ws(input int s, input logic e);
   logic x;
   n0 = 0;
   x = ~e;
   while (x !== e && n0 < 99) begin
      @(posedge aclk);
      #1;
      case (s)
         0: x = rts;
         1: x = ten;
         2: x = interrupt_status[2];
         default: x = interrupt_status[4];
      endcase
      n0++;
   end
   chk("pin", x, e);
   to(n0);
endtask
task wg(input int m);
   n0 = 0;
   while (peer.got.size() < m && n0 < 99) begin @(posedge aclk); n0++; end
   to(n0);
endtask
task do_reset;
   @(posedge aclk);
   aresetn <= 1'b0;
   repeat (3) @(posedge aclk);
   aresetn <= 1'b1;
endtask
////////////////////////////////////////////////////////////////////////////
initial begin
   aresetn = 0; awaddr = 0; wdata = 0; awvalid = 0; wvalid = 0; bready = 0;
   araddr = 0; arvalid = 0; rready = 0; cts = 0; busy = 0;
   space = 8'h37; fill = 8'h01; mstat = 8'ha5;
   repeat (3) @(posedge aclk);
   aresetn <= 1'b1;
   foreach (rows[i]) begin
      wr(8'h00, rows[i][33:26], `RESP_OKAY);
      wr(rows[i][25:18], rows[i][17:10], rows[i][1:0]);
      rd(rows[i][25:18], rows[i][9:2], rows[i][1:0]);
   end
   chk("div", div, 32'h0000_1234);
   wr(8'h00, 8'h01, `RESP_OKAY);
   rd(8'h00, 8'ha5, `RESP_OKAY);
   rd(8'h10, 8'h37, `RESP_OKAY);
   rd(8'h14, 8'h01, `RESP_OKAY);
   wr(8'h00, 8'h00, `RESP_OKAY);
   rd(8'h10, 8'h00, `RESP_SLVERR);
   wr(8'h00, 8'h03, `RESP_OKAY);
   rd(8'h14, 8'h00, `RESP_SLVERR);
   wr(8'h00, 8'hf9, `RESP_OKAY);
   rd(8'h14, 8'h01, `RESP_OKAY);
   wr(8'h20, 8'he2, `RESP_OKAY);
   rd(8'h20, 8'h02, `RESP_OKAY);
   ws(0, 1'b0);
   wr(8'h00, 8'h02, `RESP_OKAY);
   wr(8'h28, 8'h10, `RESP_OKAY);
   wr(8'h00, 8'h00, `RESP_OKAY);
   wr(8'h20, 8'he2, `RESP_OKAY);
   rd(8'h20, 8'he2, `RESP_OKAY);
   wr(8'h00, 8'h02, `RESP_OKAY);
   wr(8'h28, 8'h40, `RESP_OKAY);
   fill <= 8'h40;
   ws(0, 1'b1);
   ws(2, 1'b1);
   fill <= 8'h03;
   repeat (4) @(posedge aclk);
   chk("rts", rts, 1'b1);
   fill <= 8'h01;
   ws(0, 1'b0);
   wr(8'h28, 8'h80, `RESP_OKAY);
   busy <= 1'b1;
   cts <= 1'b1;
   repeat (4) @(posedge aclk);
   chk("ten", ten, 1'b1);
   busy <= 1'b0;
   ws(1, 1'b0);
   cts <= 1'b0;
   ws(1, 1'b1);
   wr(8'h28, 8'h20, `RESP_OKAY);
   peer.send(8'h93);
   ws(3, 1'b1);
   chk("stored", last_st, 8'h93);
   wr(8'h00, 8'h00, `RESP_OKAY);
   rd(8'h24, 8'h10, `RESP_OKAY);
   rd(8'h24, 8'h00, `RESP_OKAY);
   wr(8'h00, 8'h02, `RESP_OKAY);
   foreach (sw[i]) begin
      wr(8'h28, sw[i][23:16], `RESP_OKAY);
      k = stores;
      peer.send(sw[i][15:8]);
      ws(1, 1'b0);
      peer.send(sw[i][7:0]);
      ws(1, 1'b1);
      chk("drop", stores, k);
      peer.send(8'h41);
      chk("kept", stores, k + 1);
   end
   // Dual pairs: only the two-character sequence pauses or resumes
   wr(8'h28, 8'h0f, `RESP_OKAY);
   k = stores;
   peer.send(8'h13);
   chk("ten", ten, 1'b1);
   peer.send(8'h93);
   ws(1, 1'b0);
   peer.send(8'h11);
   peer.send(8'h91);
   ws(1, 1'b1);
   chk("seq", stores, k + 4);
   peer.stall = 3;
   foreach (tw[i]) begin
      wr(8'h28, tw[i][39:32], `RESP_OKAY);
      k = (tw[i][39:32] == 8'h0c) ? 4 : 2;
      peer.got.delete();
      fill <= 8'h05;
      wg(k / 2);
      fill <= 8'h01;
      wg(k);
      v = 0;
      foreach (peer.got[j]) if (j < 4) v[31 - 8 * j -: 8] = peer.got[j];
      chk("flow", v, tw[i][31:0]);
   end
   do_reset;
   wr(8'h00, 8'h02, `RESP_OKAY);
   rd(8'h28, `RST_BYTE, `RESP_OKAY);
   wr(8'h00, 8'h04, `RESP_OKAY);
   rd(8'h40, `RST_FLOW_HI, `RESP_OKAY);
   rd(8'h44, `RST_FLOW_LO, `RESP_OKAY);
   complete_run;
end
endmodule // test_uart_enhanced_feature_flow_ctrl
